// File: common/cstc_pkg.sv
// Package with constants for the colour sensor mode and timing control
package cstc_pkg;
  // Control register layout
  localparam int POWER_BIT    = 0;
  localparam int MODE_LSB     = 1;
  localparam int RSVD_BIT     = 4;
  localparam int TSEL_LSB     = 5;
  localparam int CTRL_W       = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Channel mode codes: 1 red, 2 green, 3 blue, 4 clear, 5 clear+red, 6 RGB, 7 all four
  localparam logic [2:0] MODE_NONE  = 3'h0;
  localparam logic [2:0] MODE_RED   = 3'h1;
  localparam logic [2:0] MODE_GREEN = 3'h2;
  localparam logic [2:0] MODE_BLUE  = 3'h3;
  localparam logic [2:0] MODE_CLR   = 3'h4;
  localparam logic [2:0] MODE_CR    = 3'h5;
  localparam logic [2:0] MODE_RGB   = 3'h6;
  localparam logic [2:0] MODE_CRGB  = 3'h7;
  // Clock and integration times
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int BASE_TIME_US   = 12500;
  localparam int BASE_CYCLES    = BASE_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int BASE_CNT_W     = 22;
  localparam int MULT_W         = 7;
  // Oscillator start-up delay in clock cycles
  localparam int OSC_START_CYC  = 2;
endpackage

// File: common/cstc_tick_if.sv
// Interface carrying the base timing tick between modules
`timescale 1ns/1ps
interface cstc_tick_if;
  logic tick;
  logic run;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface

// File: hdl/cstc_tick_gen.sv
// Base 12.5 ms tick divider, running only while the oscillator runs
`timescale 1ns/1ps
module cstc_tick_gen #(
  parameter int BASE_CYCLES = cstc_pkg::BASE_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  cstc_tick_if.src    tk
);
  logic [cstc_pkg::BASE_CNT_W-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt     <= '0;
      tk.tick <= 1'b0;
    end
    else if (!tk.run)
    begin
      cnt     <= '0;
      tk.tick <= 1'b0;
    end
    else if (cnt == cstc_pkg::BASE_CNT_W'(BASE_CYCLES - 1))
    begin
      cnt     <= '0;
      tk.tick <= 1'b1;
    end
    else
    begin
      cnt     <= cnt + 1'b1;
      tk.tick <= 1'b0;
    end
  end
endmodule

// File: hdl/cstc_ctrl.sv
// Control register, channel mode and integration timing of the colour sensor
`timescale 1ns/1ps
module cstc_ctrl #(
  parameter int BASE_CYCLES = cstc_pkg::BASE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       integ_range_sel,
  output logic      [7:0] ctrl_rd,
  output logic            osc_running,
  output logic      [1:0] integ_time_sel,
  output logic      [2:0] mode_eff,
  output logic            conv_clear,
  output logic            conv_red,
  output logic            conv_green,
  output logic            conv_blue,
  output logic            multi_channel,
  output logic      [6:0] integ_time,
  output logic            integ_done
);
  typedef enum logic [1:0] {CSTC_OFF, CSTC_START, CSTC_RUN} cstc_state_t;

  cstc_tick_if tk ();
  cstc_state_t state;
  logic        power;
  logic [2:0]  mode_req;
  logic        mode_pend;
  logic [1:0]  start_cnt;
  logic [6:0]  tick_cnt;
  logic [6:0]  next_integ_time;
  logic        osc_on;

  // Integration time in 12.5 ms units
  function automatic logic [6:0] cstc_mult(input logic rng, input logic [1:0] sel);
    logic [6:0] m;
    m = 7'h01;
    if (!rng)
      m = 7'(8'h01 << sel);
    else
      m = 7'(8'h40 >> sel);
    return m;
  endfunction

  assign osc_on = (state == CSTC_RUN);
  assign tk.run = osc_on;
  assign next_integ_time = cstc_mult(integ_range_sel, integ_time_sel);

  cstc_tick_gen #(.BASE_CYCLES(BASE_CYCLES)) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tk    (tk)
  );

  // Host writes to power, select and requested mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power          <= cstc_pkg::CTRL_RESET[cstc_pkg::POWER_BIT];
      integ_time_sel <= 2'h0;
      mode_req       <= cstc_pkg::MODE_NONE;
      mode_pend      <= 1'b0;
    end
    else if (wr_en)
    begin
      power          <= wr_data[cstc_pkg::POWER_BIT];
      integ_time_sel <= wr_data[cstc_pkg::TSEL_LSB +: 2];
      mode_req       <= wr_data[cstc_pkg::MODE_LSB +: 3];
      // Mode sent with power off or in the power-on write is dropped
      mode_pend      <= wr_data[cstc_pkg::POWER_BIT] && power;
    end
    else if (osc_on)
      mode_pend      <= 1'b0;
  end

  // Oscillator: starts after power is on, stops with power off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= CSTC_OFF;
      start_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        CSTC_OFF:
        begin
          start_cnt <= 2'h0;
          if (power)
            state <= CSTC_START;
        end
        CSTC_START:
        begin
          start_cnt <= start_cnt + 2'h1;
          if (!power)
            state <= CSTC_OFF;
          else if (start_cnt == 2'(cstc_pkg::OSC_START_CYC - 1))
            state <= CSTC_RUN;
        end
        CSTC_RUN:
          if (!power)
            state <= CSTC_OFF;
        default:
          state <= CSTC_OFF;
      endcase
    end
  end

  // Effective mode loads only while oscillator runs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_eff <= cstc_pkg::MODE_NONE;
    else if (osc_on && mode_pend && !wr_en)
      mode_eff <= mode_req;
    else if (!power)
      mode_eff <= cstc_pkg::MODE_NONE;
  end

  // Channel enables: one bit per channel, green is code 010
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_clear    <= 1'b0;
      conv_red      <= 1'b0;
      conv_green    <= 1'b0;
      conv_blue     <= 1'b0;
      multi_channel <= 1'b0;
    end
    else
    begin
      conv_clear    <= mode_eff == cstc_pkg::MODE_CLR || mode_eff == cstc_pkg::MODE_CR
                       || mode_eff == cstc_pkg::MODE_CRGB;
      conv_red      <= mode_eff == cstc_pkg::MODE_RED || mode_eff == cstc_pkg::MODE_CR
                       || mode_eff[2:1] == 2'h3 || mode_eff == cstc_pkg::MODE_RGB;
      conv_green    <= mode_eff == cstc_pkg::MODE_GREEN || mode_eff[2:1] == 2'h3;
      conv_blue     <= mode_eff == cstc_pkg::MODE_BLUE || mode_eff[2:1] == 2'h3;
      multi_channel <= mode_eff == cstc_pkg::MODE_CR || mode_eff[2:1] == 2'h3;
    end
  end

  // Integration counter in base ticks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt   <= 7'h00;
      integ_done <= 1'b0;
      integ_time <= 7'h01;
    end
    else
    begin
      integ_time <= next_integ_time;
      integ_done <= 1'b0;
      if (!osc_on || mode_eff == cstc_pkg::MODE_NONE)
        tick_cnt <= 7'h00;
      else if (tk.tick)
      begin
        if (tick_cnt >= next_integ_time - 7'h01)
        begin
          tick_cnt   <= 7'h00;
          integ_done <= 1'b1;
        end
        else
          tick_cnt <= tick_cnt + 7'h01;
      end
    end
  end

  // Readback: low nibble shows effective mode and power gated by oscillator running
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_rd     <= cstc_pkg::CTRL_RESET;
      osc_running <= 1'b0;
    end
    else
    begin
      osc_running <= osc_on;
      ctrl_rd     <= {1'b0, integ_time_sel, 1'b0, mode_eff, power && osc_on};
    end
  end

  a_mode_hold_off: assert property (@(posedge clk) disable iff (!rst_n)
    !osc_on |=> mode_eff == cstc_pkg::MODE_NONE || $stable(mode_eff))
    else $error("Mode changed while oscillator off");
  a_rd_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (!power && !osc_on) [*2] |=> ctrl_rd[3:0] == 4'h0)
    else $error("Low nibble not zero while unpowered");
  a_green_only: assert property (@(posedge clk) disable iff (!rst_n)
    mode_eff == cstc_pkg::MODE_GREEN |=> conv_green && !conv_red && !conv_clear)
    else $error("Green mode decode wrong");
  a_crgb_all: assert property (@(posedge clk) disable iff (!rst_n)
    mode_eff == cstc_pkg::MODE_CRGB |=> conv_clear && conv_red && conv_green && conv_blue)
    else $error("All channel decode wrong");
  a_blue_only: assert property (@(posedge clk) disable iff (!rst_n)
    mode_eff == cstc_pkg::MODE_BLUE |=> conv_blue && !conv_green && !multi_channel)
    else $error("Blue mode decode wrong");
  a_multi_flag: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> multi_channel == ($countones($past(mode_eff)) > 1 && $past(mode_eff) != 3'h3))
    else $error("Multi channel flag wrong");
  a_short_range: assert property (@(posedge clk) disable iff (!rst_n)
    !integ_range_sel && integ_time_sel == 2'h0 |=> integ_time == 7'h01)
    else $error("12.5 ms time wrong");
  a_long_range: assert property (@(posedge clk) disable iff (!rst_n)
    integ_range_sel && integ_time_sel == 2'h0 |=> integ_time == 7'h40)
    else $error("800 ms time wrong");
  a_dead_write_drop: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !power |=> !mode_pend)
    else $error("Mode kept from write made without power");
endmodule

// File: verif/cstc_host.sv
// Host model that writes the control byte
`timescale 1ns/1ps
module cstc_host (
  input  wire logic       clk,
  output logic            wr_en,
  output logic      [7:0] wr_data
);
  initial
  begin
    wr_en   = 1'b0;
    wr_data = 8'h00;
  end
  // One-cycle write, data scrambled once released
  task automatic put(input logic [7:0] val);
    @(posedge clk);
    #1;
    wr_en   = 1'b1;
    wr_data = {val[7:5], 1'b0, val[3:0]};
    @(posedge clk);
    #1;
    wr_en   = 1'b0;
    wr_data = ~wr_data;
  endtask
  task automatic set_mode(input logic [1:0] sel, input logic [2:0] m);
    put({1'b0, sel, 5'h01});
    put({1'b0, sel, 1'b0, m, 1'b1});
  endtask
endmodule

// File: verif/cstc_ctrl_tb.sv
// Self-checking bench for the control and timing block
`timescale 1ns/1ps
module cstc_ctrl_tb;
  localparam int BASE = 4;
  logic       clk;
  logic       rst_n;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       integ_range_sel;
  logic [7:0] ctrl_rd;
  logic       osc_running;
  logic [1:0] integ_time_sel;
  logic [2:0] mode_eff;
  logic       conv_clear, conv_red, conv_green, conv_blue;
  logic       multi_channel;
  logic [6:0] integ_time;
  logic       integ_done;
  int         num_errors;
  int         compares;
  int         cycles;
  int         n;
  cstc_host host (.clk, .wr_en, .wr_data);
  cstc_ctrl #(.BASE_CYCLES(BASE)) uut (.clk, .rst_n, .wr_en, .wr_data,
    .integ_range_sel, .ctrl_rd, .osc_running, .integ_time_sel, .mode_eff, .conv_clear,
    .conv_red, .conv_green, .conv_blue, .multi_channel, .integ_time, .integ_done);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_osc();
    for (int i = 0; i < 20 && osc_running !== 1'b1; i++)
      cyc(1);
  endtask
  // Expected {clear, red, green, blue} for a mode code
  function automatic logic [3:0] exp_conv(input logic [2:0] m);
    case (m)
      3'h1: return 4'h4;
      3'h2: return 4'h2;
      3'h3: return 4'h1;
      3'h4: return 4'h8;
      3'h5: return 4'hC;
      3'h6: return 4'h7;
      3'h7: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction
  // Integration time in 12.5 ms units for range and select
  function automatic logic [6:0] exp_units(input int r, input int s);
    logic [6:0] t [0:7];
    t = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h40, 7'h20, 7'h10, 7'h08};
    return t[r * 4 + s];
  endfunction
  task automatic t_refused();
    host.put(8'h0C);
    cyc(10);
    chk(ctrl_rd[3:0], 16'h0000);
    host.put(8'h0F);
    chk(ctrl_rd[3:0], 16'h0000);
    wait_osc();
    chk(osc_running, 16'h0001);
    cyc(8);
    chk(ctrl_rd[3:0], 16'h0001);
    chk(mode_eff, 16'h0000);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++)
    begin
      host.set_mode(2'h0, m[2:0]);
      wait_osc();
      cyc(8);
      chk(mode_eff, m[2:0]);
      chk(ctrl_rd[3:1], m[2:0]);
      chk({conv_clear, conv_red, conv_green, conv_blue}, exp_conv(m[2:0]));
      chk(multi_channel, $countones(exp_conv(m[2:0])) > 1);
    end
    host.put(8'h00);
    cyc(8);
    chk(ctrl_rd, 16'h0000);
  endtask
  task automatic period();
    n = 0;
    while (integ_done !== 1'b1 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (integ_done !== 1'b1 && n < 1000);
  endtask
  task automatic t_times();
    logic [6:0] e;
    for (int r = 0; r < 2; r++)
      for (int s = 0; s < 4; s++)
      begin
        integ_range_sel = r[0];
        host.set_mode(s[1:0], 3'h7);
        wait_osc();
        cyc(4);
        e = exp_units(r, s);
        chk(integ_time_sel, s[1:0]);
        chk(integ_time, e);
        period();
        chk(n[15:0], e * BASE);
      end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    rst_n = 1'b0;
    integ_range_sel = 1'b0;
    cyc(16);
    rst_n = 1'b1;
    chk(ctrl_rd, 16'h0000);
    chk(integ_time, 16'h0001);
    t_refused();
    t_modes();
    t_times();
    close_out();
  end
endmodule
